// ==== common/nbu_pkg.sv ====
// shared constants for the nine-bit multiprocessor serial port
`default_nettype none
package nbu_pkg;
    localparam int NBU_FRAME_BITS = 11;
    localparam int NBU_OVERSAMPLE = 16;
    localparam logic [3:0] NBU_VOTE_S0 = 4'h7;
    localparam logic [3:0] NBU_VOTE_S1 = 4'h8;
    localparam logic [3:0] NBU_VOTE_S2 = 4'h9;
    localparam logic [3:0] NBU_TICK_LAST = 4'hF;
    localparam logic [3:0] NBU_STOP_IDX = 4'hA;
    localparam logic [3:0] NBU_NINTH_IDX = 4'h9;
    localparam logic [4:0] NBU_M2_DIV_FAST = 5'h01;
    localparam logic [4:0] NBU_M2_DIV_SLOW = 5'h03;
    localparam logic [3:0] NBU_PRESCALE_12 = 4'hB;
    localparam logic [7:0] NBU_BUF_RESET = 8'h00;
    typedef enum logic [1:0] {
        NBU_MODE_0 = 2'b00,
        NBU_MODE_1 = 2'b01,
        NBU_MODE_2 = 2'b10,
        NBU_MODE_3 = 2'b11
    } nbu_mode_t;
    typedef enum logic [1:0] {
        NBU_RX_IDLE = 2'b00,
        NBU_RX_START = 2'b01,
        NBU_RX_DATA = 2'b10
    } nbu_rx_state_t;
endpackage
`default_nettype wire

// ==== logic/nbu_rate_gen.sv ====
// 8-bit auto-reload rate generator with optional divide-by-12 prescale
`default_nettype none
module nbu_rate_gen
    import nbu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fast_clk_sel,
    input wire logic [7:0] reload,
    output logic overflow
);
    logic [3:0] pre_q;
    logic [7:0] cnt_q;
    wire pre_tick = fast_clk_sel || (pre_q == NBU_PRESCALE_12);
    wire cnt_wrap = pre_tick && (cnt_q == 8'hFF);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_q <= 4'h0;
            cnt_q <= 8'h00;
        end
        else
        begin
            pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
            if (pre_tick)
                cnt_q <= cnt_wrap ? reload : cnt_q + 8'h01;
        end
    end

    assign overflow = cnt_wrap;
endmodule
`default_nettype wire

// ==== logic/nbu_uart.sv ====
// nine-bit asynchronous serial port with multiprocessor filtering
// Operation
// - frame is start, eight data, ninth, stop
// - transmit and receive run independently
// - data bits travel least significant first
// - sent ninth bit comes from tx_ninth_bit
// - mode 2 rate clk/64, or clk/32 doubled
// - buffer write starts a transmission
// - send start, data, ninth, stop in order
// - tx_done_flag set after stop bit sent
// - receive starts on falling edge when enabled
// - receive pin sampled sixteen times per bit
// - start edge resets receive bit timing
// - bit value is majority of three samples
// - unconfirmed start bit abandons the frame
// - load buffer when flag clear and filter passes
// - failed load leaves buffer and flags alone
// - mode 3 uses generator-based bit rate
// - filtering only in nine-bit modes
// - received ninth bit stored; with filtering, interrupt only when one
// - filtered data bytes raise no interrupt
// - generator overflow divided by thirty-two, or sixteen doubled
// - generator is 8-bit auto-reload timer
`default_nettype none
module nbu_uart
    import nbu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic baud_double_bit,
    input wire logic gen_fast_clk,
    input wire logic [7:0] rate_reload_reg,
    input wire logic rx_enable,
    input wire logic multiproc_filter_bit,
    input wire logic tx_ninth_bit,
    input wire logic buf_write,
    input wire logic [7:0] buf_wdata,
    input wire logic tx_done_clear,
    input wire logic rx_done_clear,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic tx_busy,
    output logic tx_done_flag,
    output logic rx_done_flag,
    output logic rx_ninth_bit,
    output logic [7:0] serial_buffer
);
    logic gen_ovf;
    logic [4:0] m2_div_q;
    logic rx_meta_q, rx_sync_q, rx_prev_q;
    logic [3:0] tx_tick_q, rx_tick_q;
    logic [3:0] tx_idx_q, rx_idx_q;
    logic [10:0] tx_shift_q;
    logic [8:0] rx_shift_q;
    logic [2:0] vote_q;
    logic tx_busy_q, tx_pin_q, tx_done_q, rx_done_q, rx_ninth_q;
    logic [7:0] buf_q;
    nbu_rx_state_t rx_state_q, rx_state_d;

    nbu_rate_gen u_rate_gen (
        .clk(clk),
        .rst(rst),
        .fast_clk_sel(gen_fast_clk),
        .reload(rate_reload_reg),
        .overflow(gen_ovf)
    );

    // sample tick: sixteen per bit in every mode
    wire nine_bit_mode = (mode == NBU_MODE_2) || (mode == NBU_MODE_3);
    wire [4:0] m2_div_last = baud_double_bit ? NBU_M2_DIV_FAST : NBU_M2_DIV_SLOW;
    wire m2_tick = (m2_div_q >= m2_div_last);
    // generator rate: doubling bit halves the extra prescale of two
    logic gen_half_q;
    wire gen_tick = gen_ovf && (baud_double_bit || gen_half_q);
    wire samp_tick = (mode == NBU_MODE_3) ? gen_tick : m2_tick;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            m2_div_q <= 5'h00;
            gen_half_q <= 1'b0;
        end
        else
        begin
            m2_div_q <= m2_tick ? 5'h00 : m2_div_q + 5'h01;
            if (gen_ovf)
                gen_half_q <= ~gen_half_q;
        end
    end

    // transmitter, runs freely of the receiver
    wire tx_bit_end = tx_busy_q && samp_tick && (tx_tick_q == NBU_TICK_LAST);
    wire tx_last = tx_bit_end && (tx_idx_q == NBU_STOP_IDX);
    wire tx_start = buf_write && !tx_busy_q && nine_bit_mode;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_busy_q <= 1'b0;
            tx_pin_q <= 1'b1;
            tx_shift_q <= 11'h7FF;
            tx_tick_q <= 4'h0;
            tx_idx_q <= 4'h0;
            tx_done_q <= 1'b0;
        end
        else
        begin
            if (tx_start)
            begin
                // shift order: start, data lsb first, ninth, stop
                tx_shift_q <= {1'b1, tx_ninth_bit, buf_wdata, 1'b0};
                tx_busy_q <= 1'b1;
                tx_tick_q <= 4'h0;
                tx_idx_q <= 4'h0;
            end
            else if (tx_busy_q && samp_tick)
            begin
                tx_tick_q <= tx_tick_q + 4'h1;
                if (tx_bit_end)
                begin
                    tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                    tx_idx_q <= tx_idx_q + 4'h1;
                    if (tx_last)
                        tx_busy_q <= 1'b0;
                end
            end
            tx_pin_q <= tx_start ? 1'b0 : (tx_busy_q && !tx_last ? tx_shift_q[0] : 1'b1);
            // set wins over clear
            if (tx_last)
                tx_done_q <= 1'b1;
            else if (tx_done_clear)
                tx_done_q <= 1'b0;
        end
    end

    // receive pin synchroniser; first stage read only by the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    wire rx_fall = rx_prev_q && !rx_sync_q;
    // majority of the three mid-bit samples
    wire vote_bit = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]);
    wire rx_bit_end = samp_tick && (rx_tick_q == NBU_TICK_LAST);
    wire rx_in_mid = samp_tick && (rx_tick_q == NBU_VOTE_S0 || rx_tick_q == NBU_VOTE_S1
        || rx_tick_q == NBU_VOTE_S2);
    wire rx_stop_end = (rx_state_q == NBU_RX_DATA) && rx_bit_end && (rx_idx_q == NBU_STOP_IDX);
    // filter only in nine-bit modes with the filter bit set
    wire filter_on = nine_bit_mode && multiproc_filter_bit;
    wire rx_load = rx_stop_end && !rx_done_q && (!filter_on || rx_shift_q[8]);

    always_comb
    begin
        rx_state_d = rx_state_q;
        unique case (rx_state_q)
            NBU_RX_IDLE:
                if (rx_fall && rx_enable && nine_bit_mode)
                    rx_state_d = NBU_RX_START;
            NBU_RX_START:
                if (rx_bit_end)
                    rx_state_d = vote_bit ? NBU_RX_IDLE : NBU_RX_DATA;
            NBU_RX_DATA:
                if (rx_stop_end)
                    rx_state_d = NBU_RX_IDLE;
            default:
                rx_state_d = NBU_RX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_state_q <= NBU_RX_IDLE;
            rx_tick_q <= 4'h0;
            rx_idx_q <= 4'h0;
            vote_q <= 3'h7;
            rx_shift_q <= 9'h000;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            if (rx_state_q == NBU_RX_IDLE)
            begin
                rx_tick_q <= 4'h0;
                rx_idx_q <= 4'h1;
            end
            else if (samp_tick)
                rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_in_mid)
                vote_q <= {vote_q[1:0], rx_sync_q};
            if (rx_state_q == NBU_RX_DATA && rx_bit_end)
            begin
                rx_idx_q <= rx_idx_q + 4'h1;
                // stop bit is not shifted, data and ninth go in lsb first
                if (rx_idx_q <= NBU_NINTH_IDX)
                    rx_shift_q <= {vote_bit, rx_shift_q[8:1]};
            end
        end
    end

    // buffer and ninth bit change only on a successful load; done flag also clears on rx_done_clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            buf_q <= NBU_BUF_RESET;
            rx_ninth_q <= 1'b0;
            rx_done_q <= 1'b0;
        end
        else
        begin
            if (rx_load)
            begin
                buf_q <= rx_shift_q[7:0];
                rx_ninth_q <= rx_shift_q[8];
            end
            if (rx_load)
                rx_done_q <= 1'b1;
            else if (rx_done_clear)
                rx_done_q <= 1'b0;
        end
    end

    assign tx_pin = tx_pin_q;
    assign tx_busy = tx_busy_q;
    assign tx_done_flag = tx_done_q;
    assign rx_done_flag = rx_done_q;
    assign rx_ninth_bit = rx_ninth_q;
    assign serial_buffer = buf_q;

    chk_tx_idle_high: assert property (@(posedge clk) disable iff (rst)
        !tx_busy_q && !$past(tx_busy_q) && !$past(tx_start) |-> tx_pin_q)
        else $error("tx pin low while idle");
    chk_tx_start_low: assert property (@(posedge clk) disable iff (rst)
        tx_start |=> !tx_pin_q && tx_busy_q)
        else $error("start bit not driven");
    chk_tx_done_set: assert property (@(posedge clk) disable iff (rst)
        tx_last |=> tx_done_q && !tx_busy_q)
        else $error("tx done not set after stop");
    chk_rx_no_load: assert property (@(posedge clk) disable iff (rst)
        !rx_load |=> buf_q == $past(buf_q) && rx_ninth_q == $past(rx_ninth_q))
        else $error("buffer changed without load");
    chk_rx_filter: assert property (@(posedge clk) disable iff (rst)
        rx_stop_end && filter_on && !rx_shift_q[8] && !rx_done_q |=> !rx_done_q)
        else $error("filtered byte raised done");
    chk_rx_load_data: assert property (@(posedge clk) disable iff (rst)
        rx_load |=> rx_done_q && buf_q == $past(rx_shift_q[7:0]))
        else $error("load did not store byte");
    chk_rx_enable: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_IDLE && !rx_enable |=> rx_state_q == NBU_RX_IDLE)
        else $error("receive started while disabled");
    chk_rx_false_start: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_START && rx_bit_end && vote_bit |=> rx_state_q == NBU_RX_IDLE)
        else $error("false start not rejected");
    // rate checks watch the fixed divider itself, so a mode switch cannot trip them
    chk_m2_rate: assert property (@(posedge clk) disable iff (rst)
        baud_double_bit && m2_tick ##1 baud_double_bit [*2]
        |-> m2_tick)
        else $error("doubled mode 2 tick spacing wrong");
    chk_m2_slow: assert property (@(posedge clk) disable iff (rst)
        !baud_double_bit && m2_tick ##1 !baud_double_bit [*4] |-> m2_tick)
        else $error("mode 2 tick spacing wrong");
    chk_m2_gap: assert property (@(posedge clk) disable iff (rst)
        m2_tick |=> !m2_tick)
        else $error("mode 2 ticks back to back");
    chk_gen_rate: assert property (@(posedge clk) disable iff (rst)
        mode == NBU_MODE_3 && samp_tick |-> gen_ovf)
        else $error("mode 3 tick without overflow");
    chk_gen_half: assert property (@(posedge clk) disable iff (rst)
        gen_tick && !baud_double_bit |-> gen_half_q)
        else $error("undoubled generator tick not halved");
    chk_tx_busy_ignore: assert property (@(posedge clk) disable iff (rst)
        tx_busy_q && buf_write && !tx_bit_end |=> tx_idx_q == $past(tx_idx_q))
        else $error("write while busy disturbed frame");
    chk_tx_ninth: assert property (@(posedge clk) disable iff (rst)
        tx_start |=> tx_shift_q[9] == $past(tx_ninth_bit))
        else $error("ninth bit not loaded");
    chk_tx_data: assert property (@(posedge clk) disable iff (rst)
        tx_start |=> tx_shift_q[8:1] == $past(buf_wdata))
        else $error("data byte not loaded");
    chk_tx_stop_high: assert property (@(posedge clk) disable iff (rst)
        tx_busy_q && tx_idx_q == NBU_STOP_IDX |=> tx_pin_q)
        else $error("stop bit not high");
    chk_tx_pin_follows: assert property (@(posedge clk) disable iff (rst)
        tx_busy_q && !tx_last |=> tx_pin_q == $past(tx_shift_q[0]))
        else $error("tx pin not following shifter");
    chk_tx_idx_range: assert property (@(posedge clk) disable iff (rst)
        tx_busy_q |-> tx_idx_q <= NBU_STOP_IDX)
        else $error("tx bit index out of frame");
    chk_tx_tick_gate: assert property (@(posedge clk) disable iff (rst)
        !tx_busy_q && !tx_start |=> tx_tick_q == $past(tx_tick_q))
        else $error("tx timing ran while idle");
    chk_tx_mode_off: assert property (@(posedge clk) disable iff (rst)
        !nine_bit_mode && !tx_busy_q |=> !tx_busy_q)
        else $error("tx started outside nine-bit modes");
    chk_tx_done_hold: assert property (@(posedge clk) disable iff (rst)
        tx_done_q && !tx_done_clear |=> tx_done_q)
        else $error("tx done dropped without clear");
    chk_tx_done_rise: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_done_q) |-> $past(tx_last))
        else $error("tx done set before stop bit");
    chk_rx_done_hold: assert property (@(posedge clk) disable iff (rst)
        rx_done_q && !rx_done_clear |=> rx_done_q)
        else $error("rx done dropped without clear");
    chk_rx_ninth_load: assert property (@(posedge clk) disable iff (rst)
        rx_load |=> rx_ninth_q == $past(rx_shift_q[8]))
        else $error("ninth bit not stored");
    chk_rx_tick_reset: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_IDLE |=> rx_tick_q == 4'h0)
        else $error("rx timing not reset while idle");
    chk_rx_start_go: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_IDLE && rx_fall && rx_enable && nine_bit_mode
        |=> rx_state_q == NBU_RX_START)
        else $error("start edge not taken");
    chk_rx_mode_off: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_IDLE && !nine_bit_mode |=> rx_state_q == NBU_RX_IDLE)
        else $error("rx started outside nine-bit modes");
    chk_rx_vote_mid: assert property (@(posedge clk) disable iff (rst)
        rx_in_mid |=> vote_q[0] == $past(rx_sync_q))
        else $error("mid-bit sample not taken");
    chk_rx_data_shift: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_DATA && rx_bit_end && rx_idx_q <= NBU_NINTH_IDX
        |=> rx_shift_q[8] == $past(vote_bit))
        else $error("voted bit not shifted in");
    chk_rx_idx_range: assert property (@(posedge clk) disable iff (rst)
        rx_state_q == NBU_RX_DATA |-> rx_idx_q >= 4'h1 && rx_idx_q <= NBU_STOP_IDX)
        else $error("rx bit index out of frame");
    // an abandoned start must never reach the buffer
    chk_rx_abandon: assert property (@(posedge clk) disable iff (rst)
        rx_state_q != NBU_RX_DATA |-> !rx_load)
        else $error("load outside data phase");
endmodule
`default_nettype wire

// ==== verification/nbu_remote_node.sv ====
// remote serial node model facing the port's pins
`default_nettype none
module nbu_remote_node
(
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] got_bits;
    int got_period;
    initial line_out = 1'b1;
    // one frame: start, data lsb first, ninth, stop
    task automatic send(input logic [7:0] data, input logic ninth, input int bit_len);
        logic [10:0] frm;
        frm = {1'b1, ninth, data, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk);
            line_out = frm[i];
            repeat (bit_len - 1) @(negedge clk);
        end
    endtask
    // short low pulse that must not pass as a start bit
    task automatic glitch(input int len);
        @(negedge clk);
        line_out = 1'b0;
        repeat (len) @(negedge clk);
        line_out = 1'b1;
    endtask
    // start bit may be stretched by tick phase, so bit time is taken from data bit0
    // data bit0 must be 1 and bit1 0
    task automatic recv();
        got_period = -1;
        @(negedge line_in);
        @(posedge line_in);
        got_bits[0] = 1'b1;
        while (line_in === 1'b1)
        begin
            @(negedge clk);
            got_period++;
        end
        repeat (got_period / 2) @(negedge clk);
        for (int i = 1; i < 10; i++)
        begin
            got_bits[i] = line_in;
            if (i < 9)
                repeat (got_period) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the nine-bit serial port
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("Error %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, baud_double_bit, gen_fast_clk, rx_enable, multiproc_filter_bit;
    logic tx_ninth_bit, buf_write, tx_done_clear, rx_done_clear, rx_pin, tx_pin;
    logic tx_busy, tx_done_flag, rx_done_flag, rx_ninth_bit;
    logic [1:0] mode;
    logic [7:0] rate_reload_reg, buf_wdata, serial_buffer;
    int mismatches = 0;
    int compares = 0;
    int per = 32;
    nbu_uart nbu_uart_inst (.clk, .rst, .mode, .baud_double_bit, .gen_fast_clk,
        .rate_reload_reg, .rx_enable, .multiproc_filter_bit, .tx_ninth_bit, .buf_write,
        .buf_wdata, .tx_done_clear, .rx_done_clear, .rx_pin, .tx_pin, .tx_busy,
        .tx_done_flag, .rx_done_flag, .rx_ninth_bit, .serial_buffer);
    nbu_remote_node nbu_remote_node_inst (.clk(clk), .line_in(tx_pin), .line_out(rx_pin));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic end_of_test();
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tx_byte(input logic [7:0] d, input logic n9);
        @(negedge clk);
        tx_ninth_bit = n9;
        buf_wdata = d;
        buf_write = 1'b1;
        @(negedge clk);
        buf_write = 1'b0;
    endtask
    task automatic clr();
        @(negedge clk);
        rx_done_clear = 1'b1;
        tx_done_clear = 1'b1;
        @(negedge clk);
        rx_done_clear = 1'b0;
        tx_done_clear = 1'b0;
    endtask
    // second write lands mid-frame and must be ignored; d needs bit0 1 and bit1 0
    task automatic tx_case(input logic [7:0] d, input logic n9, input int eper);
        fork
            nbu_remote_node_inst.recv();
            begin
                tx_byte(d, n9);
                `CHK("tx_busy", 1'b1, tx_busy)
                repeat (5) @(negedge clk);
                tx_byte(8'h00, ~n9);
            end
        join
        `CHK("tx_done_early", 1'b0, tx_done_flag)
        for (int i = 0; i < 3000 && tx_done_flag !== 1'b1; i++) @(negedge clk);
        `CHK("tx_frame", {1'b1, n9, d}, nbu_remote_node_inst.got_bits)
        `CHK("tx_bit_time", eper, nbu_remote_node_inst.got_period)
        `CHK("tx_done", 1'b1, tx_done_flag)
        `CHK("tx_busy_end", 1'b0, tx_busy)
        repeat (3 * eper) @(negedge clk);
        `CHK("tx_idle", 1'b1, tx_pin)
    endtask
    task automatic rx_case(input logic [7:0] d, input logic n9, input logic [7:0] eb,
        input logic en9, input logic ed);
        nbu_remote_node_inst.send(d, n9, per);
        repeat (40) @(negedge clk);
        `CHK("rx_done", ed, rx_done_flag)
        `CHK("rx_buffer", eb, serial_buffer)
        `CHK("rx_ninth", en9, rx_ninth_bit)
    endtask
    initial
    begin
        #400000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        {baud_double_bit, gen_fast_clk, multiproc_filter_bit, tx_ninth_bit} = 4'h0;
        {buf_write, tx_done_clear, rx_done_clear} = 3'h0;
        rst = 1'b1;
        mode = 2'h2;
        rx_enable = 1'b1;
        rate_reload_reg = 8'hFE;
        buf_wdata = 8'h00;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        `CHK("idle_pin", 1'b1, tx_pin)
        `CHK("reset_flags", 3'h0, {tx_done_flag, rx_done_flag, tx_busy})
        `CHK("reset_buffer", 8'h00, serial_buffer)
        baud_double_bit = 1'b1;
        // transmit and receive overlap in time
        fork
            tx_case(8'h35, 1'b1, 32);
            rx_case(8'h3C, 1'b0, 8'h3C, 1'b0, 1'b1);
        join
        rx_case(8'h11, 1'b1, 8'h3C, 1'b0, 1'b1);
        clr();
        mode = 2'h1;
        tx_byte(8'hA5, 1'b0);
        `CHK("tx_mode_off", 2'h2, {tx_pin, tx_busy})
        mode = 2'h2;
        tx_case(8'hC5, 1'b0, 32);
        multiproc_filter_bit = 1'b1;
        rx_case(8'h22, 1'b0, 8'h3C, 1'b0, 1'b0);
        rx_case(8'h5A, 1'b1, 8'h5A, 1'b1, 1'b1);
        clr();
        multiproc_filter_bit = 1'b0;
        nbu_remote_node_inst.glitch(3);
        repeat (400) @(negedge clk);
        `CHK("glitch_rejected", 1'b0, rx_done_flag)
        rx_case(8'hE1, 1'b0, 8'hE1, 1'b0, 1'b1);
        clr();
        rx_enable = 1'b0;
        rx_case(8'h77, 1'b1, 8'hE1, 1'b0, 1'b0);
        rx_enable = 1'b1;
        baud_double_bit = 1'b0;
        tx_case(8'h81, 1'b1, 64);
        clr();
        mode = 2'h3;
        gen_fast_clk = 1'b1;
        baud_double_bit = 1'b1;
        tx_case(8'h81, 1'b0, 32);
        end_of_test();
    end
endmodule
`default_nettype wire
